// [core/icc_pkg.sv]
package icc_pkg;

    // =====================================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] ICC_ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ICC_ADDR_DATA      = 8'h04;
    localparam logic [7:0] ICC_ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0] ICC_ADDR_IRQ_EN    = 8'h0c;
    localparam logic [7:0] ICC_ADDR_IRQ_CLR   = 8'h10;

    // =====================================================================
    // control register fields
    localparam int ICC_BIT_IDLE_STOP = 13;
    localparam int ICC_TSEL_LSB      = 10;
    localparam int ICC_CPI_LSB       = 5;
    localparam int ICC_BIT_OVF       = 4;
    localparam int ICC_BIT_BNE       = 3;
    localparam int ICC_MODE_LSB      = 0;
    localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;

    // irq status bits
    localparam int ICC_IRQ_CAPTURE  = 0;
    localparam int ICC_IRQ_OVERFLOW = 1;
    localparam int ICC_IRQ_WAKE     = 2;
    localparam int ICC_IRQ_W        = 3;

    // =====================================================================
    typedef enum logic [2:0] {
        ICC_MODE_OFF    = 3'b000,
        ICC_MODE_BOTH   = 3'b001,
        ICC_MODE_FALL   = 3'b010,
        ICC_MODE_RISE   = 3'b011,
        ICC_MODE_PRE4   = 3'b100,
        ICC_MODE_PRE16  = 3'b101,
        ICC_MODE_UNUSED = 3'b110,
        ICC_MODE_WAKE   = 3'b111
    } icc_mode_t;

    typedef enum logic [2:0] {
        ICC_TB_TIMER3 = 3'b000,
        ICC_TB_TIMER2 = 3'b001,
        ICC_TB_TIMER4 = 3'b010,
        ICC_TB_TIMER5 = 3'b011,
        ICC_TB_TIMER1 = 3'b100,
        ICC_TB_RSV5   = 3'b101,
        ICC_TB_RSV6   = 3'b110,
        ICC_TB_PCLK   = 3'b111
    } icc_tsel_t;

    localparam logic [3:0] ICC_PRE4_LAST  = 4'h3;
    localparam logic [3:0] ICC_PRE16_LAST = 4'hf;

    // timer counter values presented to the channel
    typedef struct packed {
        logic [15:0] timer1;
        logic [15:0] timer2;
        logic [15:0] timer3;
        logic [15:0] timer4;
        logic [15:0] timer5;
    } icc_timers_t;

    typedef struct packed {
        logic        idle_stop;
        icc_tsel_t   tsel;
        logic [1:0]  cpi;
        icc_mode_t   mode;
    } icc_ctrl_t;

endpackage : icc_pkg

// [core/icc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module icc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_B_I,
    input  wire logic             PUSH_I,
    input  wire logic [WIDTH-1:0] PUSH_DATA_I,
    input  wire logic             POP_I,
    input  wire logic             FLUSH_I,
    output logic      [WIDTH-1:0] HEAD_O,
    output logic                  EMPTY_O,
    output logic                  FULL_O
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;

    // a pop in the same cycle frees the head slot, so a full buffer still takes the push
    wire do_pop  = POP_I && (cnt_q != '0);
    wire do_push = PUSH_I && ((cnt_q != (AW+1)'(DEPTH)) || do_pop);

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (FLUSH_I) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wr_q <= bump(wr_q);
            if (do_pop)  rd_q <= bump(rd_q);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (do_push) mem_q[wr_q] <= PUSH_DATA_I;
    end

    assign HEAD_O  = (cnt_q == '0) ? '0 : mem_q[rd_q];
    assign EMPTY_O = (cnt_q == '0);
    assign FULL_O  = (cnt_q == (AW+1)'(DEPTH));
endmodule : icc_fifo
`default_nettype wire

// [core/icc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module icc_top
    import icc_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic               REF_CLK_I,
    input  wire logic               RST_B_I,
    input  wire logic               HSEL_I,
    input  wire logic [31:0]        HADDR_I,
    input  wire logic [1:0]         HTRANS_I,
    input  wire logic               HWRITE_I,
    input  wire logic [2:0]         HSIZE_I,
    input  wire logic [31:0]        HWDATA_I,
    input  wire logic               HREADY_I,
    output logic      [31:0]        HRDATA_O,
    output logic                    HREADYOUT_O,
    output logic                    HRESP_O,
    input  wire logic               CAPTURE_PIN_I,
    input  wire logic               CPU_IDLE_I,
    input  wire logic               CPU_SLEEP_I,
    input  wire icc_pkg::icc_timers_t TIMERS_I,
    input  wire logic [15:0]        PERIPHERAL_CLOCK_COUNT_I,
    output logic                    IRQ_O,
    output logic                    CAPTURE_IRQ_O
);
    import icc_pkg::*;

    // =====================================================================
    // bus slave
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    icc_ctrl_t   ctrl_q;
    logic [ICC_IRQ_W-1:0] irq_stat_q;
    logic [ICC_IRQ_W-1:0] irq_en_q;
    logic        ovf_q;
    logic        pop_q;

    wire addr_valid = HSEL_I && HREADY_I && HTRANS_I[1];
    wire wr_ctrl    = wr_pend_q && (addr_q == ICC_ADDR_CONTROL);
    wire wr_en      = wr_pend_q && (addr_q == ICC_ADDR_IRQ_EN);
    wire wr_clr     = wr_pend_q && (addr_q == ICC_ADDR_IRQ_CLR);
    wire rd_data    = addr_valid && !HWRITE_I && (HADDR_I[7:0] == ICC_ADDR_DATA);

    // =====================================================================
    // mode decode
    wire icc_mode_t mode = ctrl_q.mode;
    wire halted      = ctrl_q.idle_stop && CPU_IDLE_I && (mode != ICC_MODE_WAKE);
    wire mode_off    = (mode == ICC_MODE_OFF);
    wire capt_mode   = !mode_off && (mode != ICC_MODE_UNUSED) && (mode != ICC_MODE_WAKE);
    wire run         = capt_mode && !halted;

    // =====================================================================
    // edge detect on the already-synchronous pin
    logic pin_q;
    wire rise = CAPTURE_PIN_I && !pin_q;
    wire fall = !CAPTURE_PIN_I && pin_q;

    logic [3:0] pre_q;
    wire [3:0] pre_last = (mode == ICC_MODE_PRE16) ? ICC_PRE16_LAST : ICC_PRE4_LAST;
    wire is_pre  = (mode == ICC_MODE_PRE4) || (mode == ICC_MODE_PRE16);
    wire pre_hit = is_pre && rise && (pre_q == pre_last);

    logic edge_hit;
    always_comb begin
        case (mode)
            ICC_MODE_BOTH:  edge_hit = rise || fall;
            ICC_MODE_FALL:  edge_hit = fall;
            ICC_MODE_RISE:  edge_hit = rise;
            ICC_MODE_PRE4,
            ICC_MODE_PRE16: edge_hit = pre_hit;
            default:        edge_hit = 1'b0;
        endcase
    end
    wire capture = run && edge_hit;

    // =====================================================================
    // timebase mux
    logic [15:0] timebase;
    always_comb begin
        case (ctrl_q.tsel)
            ICC_TB_TIMER3: timebase = TIMERS_I.timer3;
            ICC_TB_TIMER2: timebase = TIMERS_I.timer2;
            ICC_TB_TIMER4: timebase = TIMERS_I.timer4;
            ICC_TB_TIMER5: timebase = TIMERS_I.timer5;
            ICC_TB_TIMER1: timebase = TIMERS_I.timer1;
            ICC_TB_PCLK:   timebase = PERIPHERAL_CLOCK_COUNT_I;
            default:       timebase = 16'h0000;
        endcase
    end

    // =====================================================================
    // capture fifo
    logic [15:0] head;
    logic        empty;
    logic        full;

    icc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .REF_CLK_I   (REF_CLK_I),
        .RST_B_I     (RST_B_I),
        .PUSH_I      (capture),
        .PUSH_DATA_I (timebase),
        .POP_I       (pop_q),
        .FLUSH_I     (mode_off),
        .HEAD_O      (head),
        .EMPTY_O     (empty),
        .FULL_O      (full)
    );

    wire ovf_event = capture && full && !pop_q;

    // =====================================================================
    // captures per interrupt
    logic [1:0] cpi_q;
    wire cpi_bypass = (mode == ICC_MODE_BOTH);
    // compare by magnitude so a smaller count written mid-run cannot skip an interrupt
    wire cpi_done   = cpi_bypass || (cpi_q >= ctrl_q.cpi);
    wire capt_irq   = capture && cpi_done;
    wire wake_irq   = (mode == ICC_MODE_WAKE) && rise && (CPU_SLEEP_I || CPU_IDLE_I);

    wire [ICC_IRQ_W-1:0] irq_set = {wake_irq, ovf_event, capt_irq};
    wire [ICC_IRQ_W-1:0] irq_clr = wr_clr ? HWDATA_I[ICC_IRQ_W-1:0] : '0;
    wire [ICC_IRQ_W-1:0] irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);

    // =====================================================================
    // read mux; bits 15:14 and 9:7 of control stay zero
    wire [15:0] ctrl_rd = {2'b00, ctrl_q.idle_stop, ctrl_q.tsel, 3'b000, ctrl_q.cpi,
                           ovf_q, !empty, ctrl_q.mode};
    logic [31:0] rd_mux;
    always_comb begin
        case (HADDR_I[7:0])
            ICC_ADDR_CONTROL:  rd_mux = {16'h0000, ctrl_rd};
            ICC_ADDR_DATA:     rd_mux = {16'h0000, head};
            ICC_ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
            ICC_ADDR_IRQ_EN:   rd_mux = {29'h0, irq_en_q};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // =====================================================================
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wr_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            HRDATA_O    <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            pop_q       <= 1'b0;
        end else begin
            wr_pend_q <= addr_valid && HWRITE_I;
            addr_q    <= HADDR_I[7:0];
            HRDATA_O  <= (addr_valid && !HWRITE_I) ? rd_mux : 32'h0000_0000;
            pop_q     <= rd_data && !empty;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_q.idle_stop <= ICC_CTRL_RESET[ICC_BIT_IDLE_STOP];
            ctrl_q.tsel      <= icc_tsel_t'(ICC_CTRL_RESET[ICC_TSEL_LSB +: 3]);
            ctrl_q.cpi       <= ICC_CTRL_RESET[ICC_CPI_LSB +: 2];
            ctrl_q.mode      <= icc_mode_t'(ICC_CTRL_RESET[ICC_MODE_LSB +: 3]);
        end else if (wr_ctrl) begin
            ctrl_q.idle_stop <= HWDATA_I[ICC_BIT_IDLE_STOP];
            ctrl_q.tsel      <= icc_tsel_t'(HWDATA_I[ICC_TSEL_LSB +: 3]);
            ctrl_q.cpi       <= HWDATA_I[ICC_CPI_LSB +: 2];
            ctrl_q.mode      <= icc_mode_t'(HWDATA_I[ICC_MODE_LSB +: 3]);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_q <= 1'b0;
            pre_q <= 4'h0;
            cpi_q <= 2'b00;
            ovf_q <= 1'b0;
        end else begin
            pin_q <= CAPTURE_PIN_I;
            if (mode_off || !is_pre) pre_q <= 4'h0;
            else if (run && rise) pre_q <= (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
            if (mode_off) cpi_q <= 2'b00;
            else if (capture && !cpi_bypass) cpi_q <= cpi_done ? 2'b00 : cpi_q + 2'b01;
            // overflow stays until the buffer is drained empty or the channel is turned off
            if (ovf_event) ovf_q <= 1'b1;
            else if (mode_off || empty) ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_stat_q    <= '0;
            irq_en_q      <= '0;
            IRQ_O         <= 1'b0;
            CAPTURE_IRQ_O <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_en) irq_en_q <= HWDATA_I[ICC_IRQ_W-1:0];
            IRQ_O         <= |(irq_stat_d & irq_en_q);
            CAPTURE_IRQ_O <= capt_irq || wake_irq;
        end
    end
endmodule : icc_top
`default_nettype wire

// [bench/icc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module icc_checker
    import icc_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic        REF_CLK_I,
    input wire logic        RST_B_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        CAPTURE_PIN_I,
    input wire logic        CPU_IDLE_I,
    input wire logic        CPU_SLEEP_I,
    input wire logic        CAPTURE_IRQ_O
);
    // ========
    // shadow control word, applied at the edge that ends the write data phase
    logic        wr_q;
    logic [15:0] ctl_q;
    wire         hit = HSEL_I && HREADY_I && HTRANS_I[1] && HADDR_I[7:0] == ICC_ADDR_CONTROL;
    wire [2:0]   mode = ctl_q[2:0];
    wire         halt = CPU_IDLE_I && ctl_q[13];
    wire         cpi0 = ctl_q[6:5] == 2'b00;
    wire         awake = !CPU_IDLE_I && !CPU_SLEEP_I;
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wr_q  <= 1'b0;
            ctl_q <= 16'h0;
        end else begin
            wr_q <= hit && HWRITE_I;
            if (wr_q)
                ctl_q <= HWDATA_I[15:0];
        end
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    // mode must be steady, or a pulse decided under the old mode is misjudged
    sequence s_mode(logic [2:0] m);
        mode == m && $past(mode) == m && $past(mode, 2) == m;
    endsequence
    sequence s_rd;
        hit && !HWRITE_I;
    endsequence
    property p_unimpl;
        s_rd |=> HRDATA_O[15:14] == 2'b00 && HRDATA_O[9:7] == 3'b000;
    endproperty
    property p_rise;
        s_mode(3'd3) ##0 (cpi0 && !halt && $rose(CAPTURE_PIN_I)) |=> CAPTURE_IRQ_O;
    endproperty
    property p_fall;
        s_mode(3'd2) ##0 (cpi0 && !halt && $fell(CAPTURE_PIN_I)) |=> CAPTURE_IRQ_O;
    endproperty
    property p_both;
        s_mode(3'd1) ##0 (!halt && $changed(CAPTURE_PIN_I)) |=> CAPTURE_IRQ_O;
    endproperty
    property p_off;
        s_mode(3'd0) |=> !CAPTURE_IRQ_O;
    endproperty
    property p_unused;
        s_mode(3'd6) |=> !CAPTURE_IRQ_O;
    endproperty
    property p_wake;
        s_mode(3'd7) ##0 awake |=> !CAPTURE_IRQ_O;
    endproperty
    property p_halt;
        halt && mode != 3'd7 |=> !CAPTURE_IRQ_O;
    endproperty
    property p_pre;
        CAPTURE_IRQ_O && ($past(mode) == 3'd4 || $past(mode) == 3'd5)
            |-> $past(CAPTURE_PIN_I) && !$past(CAPTURE_PIN_I, 2);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused bits set");
    a_rise: assert property (p_rise) else $error("no rise pulse");
    a_fall: assert property (p_fall) else $error("no fall pulse");
    a_both: assert property (p_both) else $error("no edge pulse");
    a_off: assert property (p_off) else $error("pulse while off");
    a_unused: assert property (p_unused) else $error("pulse in 110");
    a_wake: assert property (p_wake) else $error("wake pulse awake");
    a_halt: assert property (p_halt) else $error("pulse in idle");
    a_pre: assert property (p_pre) else $error("pulse off a rise");
endmodule : icc_checker
bind icc_top icc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
    .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .CAPTURE_PIN_I(CAPTURE_PIN_I), .CPU_IDLE_I(CPU_IDLE_I),
    .CPU_SLEEP_I(CPU_SLEEP_I), .CAPTURE_IRQ_O(CAPTURE_IRQ_O));
`default_nettype wire

// [bench/icc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model
    import icc_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    input  wire logic   want_i,
    input  wire logic   slow_i,
    output logic        pin_o,
    output icc_timers_t tmr_o,
    output logic [15:0] pclk_o
);
    // ========
    // edges reach the pin one cycle late, or three when slow
    logic [2:0] dly_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            dly_q <= 3'h0;
        else
            dly_q <= {dly_q[1:0], want_i};
    end
    assign pin_o  = slow_i ? dly_q[2] : dly_q[0];
    // distinct counts so a wrong timebase cannot match by chance
    assign tmr_o  = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    assign pclk_o = 16'h7777;
endmodule : icc_pin_model
`default_nettype wire

// [bench/icc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module icc_tb_top;
    import icc_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        want = 1'b0, slow = 1'b0, idle = 1'b0, sleep = 1'b0;
    logic        hready, hresp, pin, irq, cirq;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, irq_cnt = 32'h0;
    logic [15:0] pclk;
    icc_timers_t tmr;
    int          num_errors = 0, samples_checked = 0;
    icc_top dut_u (.REF_CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .CAPTURE_PIN_I(pin), .CPU_IDLE_I(idle),
        .CPU_SLEEP_I(sleep), .TIMERS_I(tmr), .PERIPHERAL_CLOCK_COUNT_I(pclk), .IRQ_O(irq),
        .CAPTURE_IRQ_O(cirq));
    icc_pin_model pm_u (.clk_i(clk), .rst_b_i(rst_b), .want_i(want), .slow_i(slow), .pin_o(pin),
        .tmr_o(tmr), .pclk_o(pclk));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (cirq === 1'b1) irq_cnt <= irq_cnt + 32'h1;
    // ========
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdchk
    task automatic pulses(input int n);
        repeat (n) begin
            want <= 1'b1;
            repeat (4) @(posedge clk);
            want <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask : pulses
    // ========
    task automatic t_regs();
        rdchk(ICC_ADDR_CONTROL, 32'h0);
        wr(ICC_ADDR_CONTROL, 32'h0000fff8);
        rdchk(ICC_ADDR_CONTROL, 32'h3c60);
        wr(8'h20, 32'hffffffff);
        rdchk(8'h20, 32'h0);
        wr(ICC_ADDR_CONTROL, 32'h0);
    endtask : t_regs
    task automatic t_tsel();
        logic [15:0] exp [8];
        exp = '{16'h3333, 16'h2222, 16'h4444, 16'h5555, 16'h1111, 16'h0, 16'h0, 16'h7777};
        for (int t = 0; t < 8; t++) begin
            if (t == 5 || t == 6) continue;
            wr(ICC_ADDR_CONTROL, {19'h0, t[2:0], 10'h3});
            pulses(1);
            rdchk(ICC_ADDR_CONTROL, {19'h0, t[2:0], 10'hb});
            rdchk(ICC_ADDR_DATA, {16'h0, exp[t]});
            rdchk(ICC_ADDR_CONTROL, {19'h0, t[2:0], 10'h3});
            wr(ICC_ADDR_CONTROL, 32'h0);
        end
    endtask : t_tsel
    task automatic t_cpi();
        logic [31:0] n0;
        for (int c = 0; c < 4; c++) begin
            wr(ICC_ADDR_IRQ_EN, 32'h3);
            wr(ICC_ADDR_CONTROL, {25'h0, c[1:0], 5'h3});
            n0 = irq_cnt;
            pulses(12);
            chk(irq_cnt - n0, 32'(12 / (c + 1)));
            rdchk(ICC_ADDR_CONTROL, {25'h0, c[1:0], 5'h1b});
            rdchk(ICC_ADDR_IRQ_STAT, 32'h3);
            chk({31'h0, irq}, 32'h1);
            wr(ICC_ADDR_IRQ_EN, 32'h0);
            rdchk(ICC_ADDR_IRQ_STAT, 32'h3);
            chk({31'h0, irq}, 32'h0);
            wr(ICC_ADDR_IRQ_CLR, 32'h7);
            wr(ICC_ADDR_CONTROL, 32'h0);
            rdchk(ICC_ADDR_IRQ_STAT, 32'h0);
        end
        // leave the count half done, then switch off: it must restart
        wr(ICC_ADDR_CONTROL, 32'h63);
        pulses(2);
        wr(ICC_ADDR_CONTROL, 32'h0);
        wr(ICC_ADDR_CONTROL, 32'h63);
        n0 = irq_cnt;
        pulses(3);
        chk(irq_cnt - n0, 32'h0);
        wr(ICC_ADDR_CONTROL, 32'h0);
    endtask : t_cpi
    task automatic run_mode(input logic [15:0] ctl, input logic i, input logic s, input logic [31:0] exp);
        logic [31:0] n0;
        idle <= i;
        sleep <= s;
        slow <= ctl[2];
        wr(ICC_ADDR_CONTROL, {16'h0, ctl});
        n0 = irq_cnt;
        pulses(16);
        chk(irq_cnt - n0, exp);
        idle <= 1'b0;
        sleep <= 1'b0;
        wr(ICC_ADDR_CONTROL, 32'h0);
    endtask : run_mode
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_tsel();
        t_cpi();
        run_mode(16'h0061, 1'b0, 1'b0, 32'd32);
        run_mode(16'h0002, 1'b0, 1'b0, 32'd16);
        run_mode(16'h0003, 1'b0, 1'b0, 32'd16);
        run_mode(16'h0004, 1'b0, 1'b0, 32'd4);
        run_mode(16'h0005, 1'b0, 1'b0, 32'd1);
        run_mode(16'h0006, 1'b0, 1'b0, 32'd0);
        run_mode(16'h0000, 1'b0, 1'b0, 32'd0);
        wr(ICC_ADDR_IRQ_CLR, 32'h7);
        run_mode(16'h0067, 1'b0, 1'b0, 32'd0);
        run_mode(16'h0067, 1'b0, 1'b1, 32'd16);
        rdchk(ICC_ADDR_IRQ_STAT, 32'h4);
        run_mode(16'h2003, 1'b1, 1'b0, 32'd0);
        run_mode(16'h0003, 1'b1, 1'b0, 32'd16);
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : icc_tb_top
`default_nettype wire
